// ---- txdl_pkg.sv ----
package txdl_pkg;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int BCNT_W = 13;
	localparam int BE_W = 4;
	// Descriptor word 0 layout
	localparam int FE_BIT = 31;
	localparam int STOP_BIT = 30;
	localparam int HIRQ_BIT = 29;
	localparam int BCNT_LSB = 16;
	// Descriptor word 3 layout
	localparam int DONE_BIT = 30;
	localparam logic [BCNT_W-1:0] BCNT_MAX = 13'h1FFF;
	localparam logic [ADDR_W-1:0] DONE_WORD_OFS = 32'h0000000C;
	localparam logic [ADDR_W-1:0] WORD_STEP = 32'h00000004;
	localparam logic [1:0] DESC_BURST_LEN = 2'h2;
	localparam logic [1:0] SINGLE_LEN = 2'h0;
	localparam logic [1:0] WIDX_DATAPTR = 2'h2;
	localparam logic [1:0] WIDX_NEXT = 2'h1;
	localparam logic [2:0] BYTES_PER_WORD = 3'h4;
	localparam logic [1:0] ALIGN_ZERO = 2'h0;

	typedef enum logic [2:0] {
		TXDL_IDLE = 3'b000,
		TXDL_FETCH_REQ = 3'b001,
		TXDL_FETCH_RD = 3'b010,
		TXDL_CHECK = 3'b011,
		TXDL_DATA_REQ = 3'b100,
		TXDL_DATA_RD = 3'b101,
		TXDL_DONE_WR = 3'b110,
		TXDL_HALT = 3'b111
	} txdl_state_t;

	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic [BE_W-1:0] be;
		logic frame_end;
	} txdl_fifo_word_t;

	typedef struct packed {
		logic host_irq;
		logic bad_desc;
		logic done;
	} txdl_vector_t;
endpackage

// ---- txdl_tx_dma.sv ----
// What this block does
// - Data words pass to the FIFO unswapped, little endian byte lanes kept.
// - Own data FIFO port per channel and direction; vectors to shared vector FIFO.
// - Descriptor and data pointers are full 32-bit, followed anywhere.
// - One global list end policy input governs this channel.
// - Frame end tags travel with data through the FIFO, any protocol mode.
// - First three descriptor words read as one burst on init, poll, restart or branch.
// - Channel writes fourth descriptor word when finished.
// - Init loads list base pointer and fetches the descriptor there.
// - Last bytes of a frame end section are tagged with frame end.
// - Stop flag only honoured under policy 0.
// - Policy 0: branch if stop clear, else halt until poll or restart.
// - Policy 1: branch unless current equals final; else halt until new final or restart.
// - Byte count up to 8191 bytes, 13-bit field.
// - No data and no frame end gives vector with bad descriptor flag.
// - Host interrupt flag gives vector when the done word write is granted, aborted sections included.
// - First three descriptor words stored on chip before its data is fetched.
// - Reset or init during data read drops next pointer, uses base pointer.
// - Data section may start at any byte address.
// - Done mark written on normal end or on init or transmitter reset abort.
`timescale 1ns/1ps
`default_nettype none
module txdl_tx_dma
	import txdl_pkg::*;
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic list_end_policy,
	input wire logic [txdl_pkg::ADDR_W-1:0] tx_list_base_pointer,
	input wire logic [txdl_pkg::ADDR_W-1:0] final_tx_descriptor_address,
	input wire logic final_addr_wr,
	input wire logic cmd_init,
	input wire logic cmd_poll,
	input wire logic transmit_restart_command,
	input wire logic cmd_tx_reset,
	output logic mem_req_r,
	output logic mem_we_r,
	output logic [txdl_pkg::ADDR_W-1:0] mem_addr_r,
	output logic [1:0] mem_len_r,
	output logic [txdl_pkg::DATA_W-1:0] mem_wdata_r,
	input wire logic mem_gnt,
	input wire logic mem_rvalid,
	input wire logic [txdl_pkg::DATA_W-1:0] mem_rdata,
	output logic fifo_push_r,
	output txdl_pkg::txdl_fifo_word_t fifo_word_r,
	input wire logic fifo_ready,
	output logic vec_valid_r,
	output txdl_pkg::txdl_vector_t vec_r,
	output logic tx_active_r,
	output logic [txdl_pkg::ADDR_W-1:0] current_tx_descriptor_address_r
);
	import txdl_pkg::*;

	txdl_state_t st_r, st_nxt;
	logic [ADDR_W-1:0] cur_r, cur_nxt, next_ptr_r, next_ptr_nxt, dptr_r, dptr_nxt;
	logic [BCNT_W-1:0] rem_r, rem_nxt;
	logic [1:0] widx_r, widx_nxt;
	logic fe_r, fe_nxt, stop_r, stop_nxt, hirq_r, hirq_nxt, bad_r, bad_nxt;
	logic redir_init_r, redir_init_nxt, redir_rst_r, redir_rst_nxt;
	logic mem_req_nxt, mem_we_nxt, fifo_push_nxt, vec_valid_nxt, active_nxt;
	logic [ADDR_W-1:0] mem_addr_nxt;
	logic [1:0] mem_len_nxt;
	logic [DATA_W-1:0] mem_wdata_nxt;
	txdl_fifo_word_t fifo_word_nxt;
	txdl_vector_t vec_nxt;
	logic [1:0] offs;
	logic [2:0] avail, take;
	logic [7:0] mask8;
	logic [BE_W-1:0] be_v;
	logic reactivate, at_list_end, busy;

	// Only the first word of a section can start off a word boundary
	always_comb
	begin
		offs = dptr_r[1:0];
		avail = BYTES_PER_WORD - {1'b0, offs};
		take = (rem_r < {10'h000, avail}) ? rem_r[2:0] : avail;
		mask8 = (8'h01 << take) - 8'h01;
		be_v = 4'(mask8 << offs);
	end

	assign busy = (st_r != TXDL_IDLE) && (st_r != TXDL_HALT);
	assign reactivate = list_end_policy ? (final_addr_wr || transmit_restart_command)
		: (cmd_poll || transmit_restart_command);
	assign at_list_end = list_end_policy ? (cur_r == final_tx_descriptor_address) : stop_r;

	always_comb
	begin
		st_nxt = st_r;
		cur_nxt = cur_r;
		next_ptr_nxt = next_ptr_r;
		dptr_nxt = dptr_r;
		rem_nxt = rem_r;
		widx_nxt = widx_r;
		fe_nxt = fe_r;
		stop_nxt = stop_r;
		hirq_nxt = hirq_r;
		bad_nxt = bad_r;
		redir_init_nxt = redir_init_r;
		redir_rst_nxt = redir_rst_r;
		mem_req_nxt = mem_req_r && !mem_gnt;
		mem_we_nxt = mem_we_r;
		mem_addr_nxt = mem_addr_r;
		mem_len_nxt = mem_len_r;
		mem_wdata_nxt = mem_wdata_r;
		fifo_push_nxt = fifo_push_r && !fifo_ready;
		fifo_word_nxt = fifo_word_r;
		vec_valid_nxt = 1'b0;
		vec_nxt = vec_r;
		active_nxt = busy;
		if (busy && cmd_init)
			redir_init_nxt = 1'b1;
		if (busy && cmd_tx_reset)
			redir_rst_nxt = 1'b1;
		unique case (st_r)
			TXDL_IDLE, TXDL_HALT:
			begin
				if (cmd_init)
				begin
					cur_nxt = tx_list_base_pointer;
					st_nxt = TXDL_FETCH_REQ;
					mem_req_nxt = 1'b1;
					mem_we_nxt = 1'b0;
					mem_len_nxt = DESC_BURST_LEN;
					mem_addr_nxt = tx_list_base_pointer;
				end
				else if (cmd_tx_reset)
					next_ptr_nxt = tx_list_base_pointer;
				else if (st_r == TXDL_HALT && reactivate)
				begin
					cur_nxt = next_ptr_r;
					st_nxt = TXDL_FETCH_REQ;
					mem_req_nxt = 1'b1;
					mem_we_nxt = 1'b0;
					mem_len_nxt = DESC_BURST_LEN;
					mem_addr_nxt = next_ptr_r;
				end
			end
			TXDL_FETCH_REQ:
			begin
				widx_nxt = 2'h0;
				if (mem_gnt)
					st_nxt = TXDL_FETCH_RD;
			end
			TXDL_FETCH_RD:
			begin
				if (mem_rvalid)
				begin
					widx_nxt = widx_r + 2'h1;
					if (widx_r == 2'h0)
					begin
						fe_nxt = mem_rdata[FE_BIT];
						stop_nxt = mem_rdata[STOP_BIT];
						hirq_nxt = mem_rdata[HIRQ_BIT];
						rem_nxt = mem_rdata[BCNT_LSB +: BCNT_W];
					end
					else if (widx_r == WIDX_NEXT)
						next_ptr_nxt = mem_rdata;
					else
					begin
						dptr_nxt = mem_rdata;
						st_nxt = TXDL_CHECK;
					end
				end
			end
			TXDL_CHECK:
			begin
				bad_nxt = (rem_r == '0) && !fe_r;
				if (rem_r == '0)
				begin
					// An empty frame end section still needs its tag in the FIFO
					if (fe_r)
					begin
						fifo_push_nxt = 1'b1;
						fifo_word_nxt = '{data: '0, be: '0, frame_end: 1'b1};
					end
					st_nxt = TXDL_DONE_WR;
					mem_req_nxt = 1'b1;
					mem_we_nxt = 1'b1;
					mem_len_nxt = SINGLE_LEN;
					mem_addr_nxt = cur_r + DONE_WORD_OFS;
					mem_wdata_nxt = '0;
					mem_wdata_nxt[DONE_BIT] = 1'b1;
				end
				else
					st_nxt = TXDL_DATA_REQ;
			end
			TXDL_DATA_REQ:
			begin
				if (redir_init_r || redir_rst_r || rem_r == '0)
				begin
					st_nxt = TXDL_DONE_WR;
					mem_req_nxt = 1'b1;
					mem_we_nxt = 1'b1;
					mem_len_nxt = SINGLE_LEN;
					mem_addr_nxt = cur_r + DONE_WORD_OFS;
					mem_wdata_nxt = '0;
					mem_wdata_nxt[DONE_BIT] = 1'b1;
				end
				else if (!fifo_push_r)
				begin
					// One word in flight keeps FIFO back-pressure exact
					st_nxt = TXDL_DATA_RD;
					mem_req_nxt = 1'b1;
					mem_we_nxt = 1'b0;
					mem_len_nxt = SINGLE_LEN;
					mem_addr_nxt = {dptr_r[ADDR_W-1:2], ALIGN_ZERO};
				end
			end
			TXDL_DATA_RD:
			begin
				if (mem_rvalid)
				begin
					fifo_push_nxt = 1'b1;
					fifo_word_nxt.data = mem_rdata;
					fifo_word_nxt.be = be_v;
					fifo_word_nxt.frame_end = fe_r && (rem_r == {10'h000, take});
					rem_nxt = rem_r - {10'h000, take};
					dptr_nxt = {dptr_r[ADDR_W-1:2], ALIGN_ZERO} + WORD_STEP;
					st_nxt = TXDL_DATA_REQ;
				end
			end
			TXDL_DONE_WR:
			begin
				if (mem_gnt)
				begin
					vec_valid_nxt = hirq_r || bad_r;
					vec_nxt = '{host_irq: hirq_r, bad_desc: bad_r, done: 1'b1};
					redir_init_nxt = 1'b0;
					redir_rst_nxt = 1'b0;
					if (redir_init_r || redir_rst_r)
						next_ptr_nxt = tx_list_base_pointer;
					if (redir_init_r || (!redir_rst_r && !at_list_end))
					begin
						cur_nxt = redir_init_r ? tx_list_base_pointer : next_ptr_r;
						st_nxt = TXDL_FETCH_REQ;
						mem_req_nxt = 1'b1;
						mem_we_nxt = 1'b0;
						mem_len_nxt = DESC_BURST_LEN;
						mem_addr_nxt = redir_init_r ? tx_list_base_pointer : next_ptr_r;
					end
					else
						st_nxt = TXDL_HALT;
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
		begin
			st_r <= TXDL_IDLE;
			cur_r <= '0;
			next_ptr_r <= '0;
			dptr_r <= '0;
			rem_r <= '0;
			widx_r <= '0;
			fe_r <= 1'b0;
			stop_r <= 1'b0;
			hirq_r <= 1'b0;
			bad_r <= 1'b0;
			redir_init_r <= 1'b0;
			redir_rst_r <= 1'b0;
			mem_req_r <= 1'b0;
			mem_we_r <= 1'b0;
			mem_addr_r <= '0;
			mem_len_r <= '0;
			mem_wdata_r <= '0;
			fifo_push_r <= 1'b0;
			fifo_word_r <= '0;
			vec_valid_r <= 1'b0;
			vec_r <= '0;
			tx_active_r <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			cur_r <= cur_nxt;
			next_ptr_r <= next_ptr_nxt;
			dptr_r <= dptr_nxt;
			rem_r <= rem_nxt;
			widx_r <= widx_nxt;
			fe_r <= fe_nxt;
			stop_r <= stop_nxt;
			hirq_r <= hirq_nxt;
			bad_r <= bad_nxt;
			redir_init_r <= redir_init_nxt;
			redir_rst_r <= redir_rst_nxt;
			mem_req_r <= mem_req_nxt;
			mem_we_r <= mem_we_nxt;
			mem_addr_r <= mem_addr_nxt;
			mem_len_r <= mem_len_nxt;
			mem_wdata_r <= mem_wdata_nxt;
			fifo_push_r <= fifo_push_nxt;
			fifo_word_r <= fifo_word_nxt;
			vec_valid_r <= vec_valid_nxt;
			vec_r <= vec_nxt;
			tx_active_r <= active_nxt;
		end
	end

	assign current_tx_descriptor_address_r = cur_r;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	AST_DESC_BURST: assert property (
		(st_r == TXDL_FETCH_REQ && mem_req_r) |-> (mem_len_r == DESC_BURST_LEN && !mem_we_r))
		else $error("descriptor fetch is not a three word read burst");
	AST_DONE_WORD: assert property (
		(st_r == TXDL_DONE_WR && mem_req_r) |-> (mem_we_r && mem_wdata_r[DONE_BIT]
			&& mem_addr_r == cur_r + DONE_WORD_OFS))
		else $error("done word not written to fourth descriptor word");
	AST_BAD_VEC: assert property (
		(vec_valid_r && vec_r.bad_desc) |-> ($past(rem_r) == '0 && !$past(fe_r)))
		else $error("bad descriptor vector without an empty descriptor");
	AST_HIRQ_VEC: assert property (
		(st_r == TXDL_DONE_WR && mem_gnt && hirq_r) |=> (vec_valid_r && vec_r.host_irq))
		else $error("host interrupt vector missing after section");
	AST_FE_TAG: assert property (
		(st_r == TXDL_DATA_RD && mem_rvalid && fe_r && rem_r == {10'h000, take})
			|=> (fifo_push_r && fifo_word_r.frame_end))
		else $error("last bytes of frame end section not tagged");
	AST_POLICY0: assert property (
		(st_r == TXDL_DONE_WR && mem_gnt && !redir_init_r && !redir_rst_r && !list_end_policy)
			|=> (st_r == (stop_r ? TXDL_HALT : TXDL_FETCH_REQ)))
		else $error("policy 0 list end decision wrong");
	AST_POLICY1: assert property (
		(st_r == TXDL_DONE_WR && mem_gnt && !redir_init_r && !redir_rst_r && list_end_policy
			&& cur_r != final_tx_descriptor_address) |=> (st_r == TXDL_FETCH_REQ && cur_r == $past(next_ptr_r)))
		else $error("policy 1 did not branch on differing addresses");
	AST_RESET_BASE: assert property (
		(st_r == TXDL_DONE_WR && mem_gnt && redir_rst_r && !redir_init_r)
			|=> (st_r == TXDL_HALT && next_ptr_r == $past(tx_list_base_pointer)))
		else $error("transmitter reset did not redirect to base pointer");
	AST_UNALIGNED: assert property (
		(st_r == TXDL_DATA_RD && mem_req_r) |-> (mem_addr_r[1:0] == ALIGN_ZERO))
		else $error("data read not word aligned");
	AST_COUNT_MAX: assert property (
		rem_r <= BCNT_MAX)
		else $error("remaining byte count above maximum");

	COV_BRANCH: cover property ((st_r == TXDL_DONE_WR && mem_gnt) ##1 st_r == TXDL_FETCH_REQ);
	COV_HALT_POLL: cover property (st_r == TXDL_HALT ##[1:50] st_r == TXDL_FETCH_REQ);
	COV_BAD: cover property (vec_valid_r && vec_r.bad_desc);
	COV_RESET_ABORT: cover property (st_r == TXDL_DATA_RD && cmd_tx_reset);
endmodule // txdl_tx_dma
`default_nettype wire

// ---- txdl_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module txdl_mem_model
	import txdl_pkg::*;
(
	input wire logic ref_clk,
	input wire logic mem_req_r,
	input wire logic mem_we_r,
	input wire logic [txdl_pkg::ADDR_W-1:0] mem_addr_r,
	input wire logic [1:0] mem_len_r,
	input wire logic [txdl_pkg::DATA_W-1:0] mem_wdata_r,
	output var logic mem_gnt,
	output var logic mem_rvalid,
	output var logic [txdl_pkg::DATA_W-1:0] mem_rdata
);
	// Host builds whole descriptors here before any command can reach them
	logic [31:0] mem [256];
	int lat = 0;
	logic [7:0] idx;
	logic w;
	logic [1:0] n;
	initial
	begin
		mem_gnt = 1'b0;
		mem_rvalid = 1'b0;
		mem_rdata = 32'h5A5A5A5A;
		forever
		begin
			@(posedge ref_clk);
			if (mem_req_r === 1'b1)
			begin
				idx = mem_addr_r[9:2];
				w = mem_we_r;
				n = mem_len_r;
				repeat (lat) @(posedge ref_clk);
				mem_gnt <= 1'b1;
				if (w)
					mem[idx] <= mem_wdata_r;
				@(posedge ref_clk);
				mem_gnt <= 1'b0;
				for (int i = 0; i <= int'(n) && !w; i++)
				begin
					mem_rvalid <= 1'b1;
					mem_rdata <= mem[idx + 8'(i)];
					@(posedge ref_clk);
				end
				mem_rvalid <= 1'b0;
				// Released bus flips so a stale word never looks fresh
				mem_rdata <= ~mem_rdata;
			end
		end
	end
endmodule // txdl_mem_model
`default_nettype wire

// ---- txdl_tx_dma_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module txdl_tx_dma_tb;
	import txdl_pkg::*;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic list_end_policy = 1'b0;
	logic [31:0] final_addr = 32'h00000000;
	logic [4:0] cmd = 5'h00;
	logic fifo_ready = 1'b1;
	logic stall = 1'b0;
	logic [1:0] cyc = 2'h0;
	logic mem_req, mem_we, mem_gnt, mem_rvalid, fifo_push, vec_valid, tx_active;
	logic [1:0] mem_len;
	logic [31:0] mem_addr, mem_wdata, mem_rdata, cur_addr;
	txdl_fifo_word_t fw;
	txdl_vector_t vec;
	txdl_fifo_word_t pq[$];
	txdl_vector_t vq[$];
	int errors = 0;
	int checks = 0;

	txdl_tx_dma dut_u (.ref_clk(ref_clk), .nrst(nrst), .list_end_policy(list_end_policy),
		.tx_list_base_pointer(32'h00000100), .final_tx_descriptor_address(final_addr),
		.final_addr_wr(cmd[4]), .cmd_init(cmd[0]), .cmd_poll(cmd[1]), .transmit_restart_command(cmd[2]),
		.cmd_tx_reset(cmd[3]), .mem_req_r(mem_req), .mem_we_r(mem_we), .mem_addr_r(mem_addr),
		.mem_len_r(mem_len), .mem_wdata_r(mem_wdata), .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid),
		.mem_rdata(mem_rdata), .fifo_push_r(fifo_push), .fifo_word_r(fw), .fifo_ready(fifo_ready),
		.vec_valid_r(vec_valid), .vec_r(vec), .tx_active_r(tx_active), .current_tx_descriptor_address_r(cur_addr));
	txdl_mem_model u_mem (.ref_clk(ref_clk), .mem_req_r(mem_req), .mem_we_r(mem_we), .mem_addr_r(mem_addr),
		.mem_len_r(mem_len), .mem_wdata_r(mem_wdata), .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid),
		.mem_rdata(mem_rdata));

	initial
		forever
			#12.5 ref_clk = ~ref_clk;

	always @(posedge ref_clk)
	begin
		cyc <= cyc + 2'h1;
		fifo_ready <= stall ? cyc[1] : 1'b1;
		if (fifo_push === 1'b1 && fifo_ready === 1'b1)
			pq.push_back(fw);
		if (vec_valid === 1'b1)
			vq.push_back(vec);
	end

	task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
		checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask

	task automatic give_verdict();
		$display("Counts: %0d checks, %0d errors", checks, errors);
		if (errors == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic desc(input logic [31:0] a, input logic [2:0] f, input logic [12:0] n, input logic [31:0] nx,
		input logic [31:0] dp);
		u_mem.mem[a[9:2]] = {f, n, 16'h0000};
		u_mem.mem[a[9:2] + 8'h01] = nx;
		u_mem.mem[a[9:2] + 8'h02] = dp;
		u_mem.mem[a[9:2] + 8'h03] = 32'h00000000;
	endtask

	task automatic pulse(input int b);
		@(posedge ref_clk);
		cmd[b] <= 1'b1;
		@(posedge ref_clk);
		cmd <= 5'h00;
	endtask

	// Bounded wait for the channel to go quiet; the capture queues are left untouched for the caller
	task automatic wait_halt(input string name);
		int k;
		k = 0;
		repeat (4) @(posedge ref_clk);
		while (tx_active !== 1'b0 && k < 3000)
		begin
			@(posedge ref_clk);
			k++;
		end
		repeat (4) @(posedge ref_clk);
		check(64'(k < 3000), 64'h1, "channel never stopped");
		$display("Test %s done", name);
	endtask

	task automatic word(input int i, input logic [31:0] d, input logic [3:0] be, input logic fe);
		check({pq[i].data, pq[i].be, pq[i].frame_end}, {d, be, fe}, "fifo word");
	endtask

	initial
	begin
		repeat (20000) @(posedge ref_clk);
		errors++;
		$display("CHECK FAILED at %0t: timeout", $time);
		give_verdict();
	end

	initial
	begin
		for (int i = 0; i < 128; i++)
			u_mem.mem[8'h80 + 8'(i)] = 32'hA0B0C000 + 32'(i);
		desc(32'h100, 3'b001, 13'h0006, 32'h110, 32'h203);
		desc(32'h110, 3'b110, 13'h0000, 32'h120, 32'h0);
		desc(32'h120, 3'b010, 13'h0000, 32'h130, 32'h0);
		desc(32'h130, 3'b110, 13'h0004, 32'h140, 32'h304);
		desc(32'h140, 3'b100, 13'h0004, 32'h150, 32'h308);
		desc(32'h150, 3'b100, 13'h0000, 32'h100, 32'h0);
		repeat (10) @(posedge ref_clk);
		nrst <= 1'b1;
		pulse(0);
		wait_halt("init");
		check(pq.size(), 4, "push count");
		word(0, 32'hA0B0C000, 4'h8, 1'b0);
		word(1, 32'hA0B0C001, 4'hF, 1'b0);
		word(2, 32'hA0B0C002, 4'h1, 1'b0);
		check({pq[3].be, pq[3].frame_end}, 5'h01, "empty frame end");
		check({vq.size(), vq[0]}, {32'd1, 3'b101}, "host irq vector");
		check(u_mem.mem[8'h43], 32'h40000000, "done word");
		check(u_mem.mem[8'h47], 32'h40000000, "done word");
		check(cur_addr, 32'h110, "stop address");
		pq.delete();
		vq.delete();
		u_mem.lat = 3;
		pulse(1);
		wait_halt("poll");
		check({vq.size(), vq[0]}, {32'd1, 3'b011}, "bad vector");
		check(pq.size(), 0, "bad pushes");
		check(u_mem.mem[8'h4B], 32'h40000000, "bad done");
		check(cur_addr, 32'h120, "poll address");
		pq.delete();
		vq.delete();
		list_end_policy <= 1'b1;
		final_addr <= 32'h140;
		stall <= 1'b1;
		pulse(2);
		wait_halt("final address");
		check(pq.size(), 2, "policy 1 pushes");
		word(0, 32'hA0B0C041, 4'hF, 1'b1);
		word(1, 32'hA0B0C042, 4'hF, 1'b1);
		check(cur_addr, 32'h140, "final stop");
		pulse(1);
		repeat (8) @(posedge ref_clk);
		check({tx_active, cur_addr}, {1'b0, 32'h140}, "poll ignored");
		final_addr <= 32'h150;
		pulse(4);
		wait_halt("new final");
		check(cur_addr, 32'h150, "new final stop");
		check(u_mem.mem[8'h57], 32'h40000000, "fe only done");
		pq.delete();
		vq.delete();
		list_end_policy <= 1'b0;
		pulse(0);
		for (int k = 0; k < 500 && pq.size() == 0; k++)
			@(posedge ref_clk);
		pulse(0);
		wait_halt("init mid data");
		// The abort lands while the second data word is still in flight
		check({pq.size(), vq.size()}, {32'd6, 32'd2}, "redirect to base");
		check(cur_addr, 32'h110, "redirect stop");
		pq.delete();
		stall <= 1'b0;
		pulse(3);
		repeat (6) @(posedge ref_clk);
		check(tx_active, 1'b0, "reset keeps halted");
		pulse(1);
		wait_halt("reset then poll");
		check({pq.size(), cur_addr}, {32'd4, 32'h110}, "reset redirect");
		give_verdict();
	end
endmodule // txdl_tx_dma_tb
`default_nettype wire
